// ===== common/mhr_pkg.sv
// Purpose: Shared constants and types for the monitor holding register bank.
// Assumes: Register addresses are 16-bit word indices; data words are 16 bits.
// Notes: Pair helpers name every upper word that owns a latched lower word.
package mhr_pkg;

  localparam int ADDR_W = 16;
  localparam int DATA_W = 16;
  localparam int QTY_W = 16;
  localparam int STR_W = 160;
  localparam int STR_WORDS = 10;

  localparam logic [15:0] ADDR_H2_UP = 16'h0000;
  localparam logic [15:0] ADDR_H2_LO = 16'h0001;
  localparam logic [15:0] ADDR_TEMP = 16'h0008;
  localparam logic [15:0] ADDR_RATE_DAY_UP = 16'h000d;
  localparam logic [15:0] ADDR_RATE_DAY_LO = 16'h000e;
  localparam logic [15:0] ADDR_RATE_WEEK_UP = 16'h000f;
  localparam logic [15:0] ADDR_RATE_WEEK_LO = 16'h0010;
  localparam logic [15:0] ADDR_RATE_MONTH_UP = 16'h0011;
  localparam logic [15:0] ADDR_RATE_MONTH_LO = 16'h0012;
  localparam logic [15:0] ADDR_MODEL_STR = 16'h001f;
  localparam logic [15:0] ADDR_PROD_SN_STR = 16'h0029;
  localparam logic [15:0] ADDR_SENS_SN_STR = 16'h0033;
  localparam logic [15:0] ADDR_BUILD_MD = 16'h0051;
  localparam logic [15:0] ADDR_BUILD_YR = 16'h0052;
  localparam logic [15:0] ADDR_FCAL_MD = 16'h0053;
  localparam logic [15:0] ADDR_FCAL_YR = 16'h0054;
  localparam logic [15:0] ADDR_GCAL_MD = 16'h0057;
  localparam logic [15:0] ADDR_GCAL_YR = 16'h0058;
  localparam logic [15:0] ADDR_FW_STR = 16'h0059;
  localparam logic [15:0] ADDR_STATUS = 16'h006f;
  localparam logic [15:0] ADDR_LAST = 16'h006f;

  localparam logic [31:0] RATE_BIAS = 32'h01312d00;
  localparam logic [15:0] TEMP_OFFSET = 16'h2710;

  localparam logic [7:0] FUNC_RD_EXC = 8'h83;
  localparam logic [7:0] FUNC_WR_EXC = 8'h86;
  localparam logic [7:0] EXC_ILLEGAL_ADDR = 8'h02;
  localparam logic [7:0] EXC_ILLEGAL_VALUE = 8'h03;

  localparam logic [15:0] RESET_WORD = 16'h0000;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_READ = 2'b01,
    ST_WRITE = 2'b10
  } mhr_state_t;

  function automatic logic mhr_is_pair_upper(input logic [15:0] a);
    return (a == ADDR_H2_UP) || (a == ADDR_RATE_DAY_UP) || (a == ADDR_RATE_WEEK_UP) ||
           (a == ADDR_RATE_MONTH_UP) || (a == ADDR_BUILD_MD) || (a == ADDR_FCAL_MD) ||
           (a == ADDR_GCAL_MD);
  endfunction

  function automatic logic mhr_is_pair_lower(input logic [15:0] a);
    return mhr_is_pair_upper(a - 16'h0001) && (a != 16'h0000);
  endfunction

endpackage

// ===== tb/mhr_master_model.sv
// Purpose: Polling master that requests and collects register words.
// Assumes: Tasks are entered just after a rising edge.
// Notes: Released valid, address and write data lines show the inverse of their last value.
`timescale 1ns/1ns
`default_nettype none
module mhr_master_model
  import mhr_pkg::*;
(
  input wire logic core_clk,
  input wire logic reqReady,
  input wire logic wrReady,
  input wire logic rdValid,
  input wire logic [DATA_W-1:0] rdData,
  input wire logic done,
  input wire logic excValid,
  output logic reqValid,
  output logic reqWrite,
  output logic [ADDR_W-1:0] reqAddr,
  output logic [QTY_W-1:0] reqQty,
  output logic wrValid,
  output logic [DATA_W-1:0] wrData
);
  logic [15:0] words[$];
  logic gotExc;
  initial begin
    reqValid = 1'b0;
    reqWrite = 1'b0;
    reqAddr = 16'h0000;
    reqQty = 16'h0000;
    wrValid = 1'b0;
    wrData = 16'h0000;
  end
  task automatic issue(input logic wr, input logic [15:0] a, input logic [15:0] q);
    reqValid = 1'b1;
    reqWrite = wr;
    reqAddr = a;
    reqQty = q;
    while (!reqReady) @(posedge core_clk) #1;
    @(posedge core_clk) #1;
    reqValid = 1'b0;
    reqAddr = ~a;
  endtask
  // Words come back in address order, so a pair is fetched upper first
  task automatic xfer(input logic wr, input logic [15:0] a, input logic [15:0] q);
    words.delete();
    gotExc = 1'b0;
    issue(wr, a, q);
    for (int n = 0; n < 200; n++) begin
      if (rdValid) words.push_back(rdData);
      if (excValid) gotExc = 1'b1;
      if (done || excValid) break;
      @(posedge core_clk) #1;
    end
  endtask
  task automatic write(input logic [15:0] a, input logic [15:0] q, input logic [15:0] d[$],
      input int gap);
    issue(1'b1, a, q);
    for (int i = 0; i < q; i++) begin
      wrValid = 1'b1;
      wrData = d[i];
      for (int k = 0; k < 50 && !wrReady; k++) @(posedge core_clk) #1;
      @(posedge core_clk) #1;
      if (gap > 0 || i == q - 1) begin
        wrValid = 1'b0;
        wrData = ~wrData;
        repeat (gap) @(posedge core_clk) #1;
      end
    end
  endtask
endmodule
`default_nettype wire

// ===== tb/mhr_regbank_monitor.sv
// Purpose: Port checker for the holding register bank.
// Assumes: Value inputs hold still while a read is in flight.
// Notes: Attached by the bind at the foot.
`timescale 1ns/1ns
`default_nettype none
module mhr_regbank_monitor
  import mhr_pkg::*;
(
  input wire logic core_clk,
  input wire logic srst,
  input wire logic reqValid,
  input wire logic reqWrite,
  input wire logic [ADDR_W-1:0] reqAddr,
  input wire logic [QTY_W-1:0] reqQty,
  input wire logic reqReady,
  input wire logic [DATA_W-1:0] wrData,
  input wire logic rdValid,
  input wire logic [DATA_W-1:0] rdData,
  input wire logic excValid,
  input wire logic [7:0] excFunc,
  input wire logic [7:0] excCode,
  input wire logic commitValid,
  input wire logic [31:0] commitData,
  input wire logic commitWide,
  input wire logic [31:0] h2Ppm,
  input wire logic signed [15:0] tempCenti
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (srst);
  logic tk;
  logic rd;
  logic one;
  logic over;
  assign tk = reqValid && reqReady;
  assign rd = tk && !reqWrite;
  assign one = rd && reqQty == 16'h0001;
  // Widened sum so a start near the top cannot wrap past the check
  assign over = reqQty != 16'h0000 && ({1'b0, reqAddr} + {1'b0, reqQty}) > 17'h00070;
  a_range_exc_code: assert property (tk && over |=> excValid && excCode == 8'h02)
    else $error("overrun not refused");
  a_read_exc_func: assert property (rd && over |=> excFunc == 8'h83)
    else $error("wrong read exception function");
  a_h2_upper_word: assert property (one && reqAddr == 16'h0000 |->
    ##2 rdValid && rdData == $past(h2Ppm[31:16]))
    else $error("hydrogen upper word wrong");
  a_pair_latch_low: assert property (rd && reqAddr == 16'h0000 && reqQty == 16'h0002
    |-> ##3 rdData == $past(h2Ppm[15:0], 2))
    else $error("lower word not from latch");
  a_temp_offset: assert property (one && reqAddr == 16'h0008 |->
    ##2 rdData == $past(tempCenti) + 16'h2710)
    else $error("temperature scaling wrong");
  a_string_nul: assert property (one && reqAddr == 16'h0028 |->
    ##2 rdValid && rdData[7:0] == 8'h00)
    else $error("string not terminated");
  a_reserved_zero: assert property (one && reqAddr inside {[16'h0013:16'h001e], [16'h0063:16'h006e]}
    |-> ##2 rdData == 16'h0000)
    else $error("reserved word not zero");
  a_wide_commit: assert property (commitValid && commitWide |->
    commitData[15:0] == $past(wrData))
    else $error("wide commit lower half wrong");
  c_pair_read: cover property (rd && reqQty == 16'h0002);
  c_refused: cover property (excValid);
  c_wide: cover property (commitValid && commitWide);
endmodule
bind mhr_regbank mhr_regbank_monitor mon (.core_clk, .srst, .reqValid, .reqWrite, .reqAddr,
  .reqQty, .reqReady, .wrData, .rdValid, .rdData, .excValid, .excFunc, .excCode, .commitValid,
  .commitData, .commitWide, .h2Ppm, .tempCenti);
`default_nettype wire

// ===== tb/test_mhr_regbank.sv
// Purpose: Self-checking bench for the holding register bank.
// Assumes: Value inputs change only between requests.
// Notes: Serial and firmware strings stay constant.
`timescale 1ns/1ns
`default_nettype none
module test_mhr_regbank;
  import mhr_pkg::*;
  logic core_clk = 1'b0;
  logic srst = 1'b1;
  logic reqValid, reqWrite, reqReady, wrValid, wrReady, rdValid, done, excValid;
  logic commitValid, commitWide;
  logic [15:0] reqAddr, reqQty, wrData, rdData, commitAddr;
  logic [7:0] excFunc, excCode;
  logic [31:0] commitData;
  logic [31:0] h2Ppm = 32'h0;
  logic signed [15:0] tempCenti = 16'h0;
  logic signed [31:0] rateDay = 32'h0, rateWeek = 32'h0, rateMonth = 32'h0;
  logic [STR_W-1:0] modelStr = "ABCDEFGHIJKLMNOPQRST";
  logic [STR_W-1:0] prodSerialStr = "P1", sensSerialStr = "S1", fwRevStr = "F1";
  logic [7:0] buildMonth = 8'h0c, buildDay = 8'h1f, fcalMonth = 8'h01, fcalDay = 8'h02;
  logic [7:0] gcalMonth = 8'h03, gcalDay = 8'h04;
  logic [15:0] buildYear = 16'h07e8, fcalYear = 16'h07e9, gcalYear = 16'h07ea;
  logic [15:0] statusFlags = 16'h00a5;
  int numErrors = 0, samplesChecked = 0, cycles = 0, nCommit = 0;
  always #10 core_clk = ~core_clk;
  mhr_regbank dut (.core_clk, .srst, .reqValid, .reqWrite, .reqAddr, .reqQty, .reqReady,
    .wrValid, .wrData, .wrReady, .rdValid, .rdData, .done, .excValid, .excFunc, .excCode,
    .commitValid, .commitAddr, .commitData, .commitWide, .h2Ppm, .tempCenti, .rateDay,
    .rateWeek, .rateMonth, .modelStr, .prodSerialStr, .sensSerialStr, .fwRevStr, .buildMonth,
    .buildDay, .buildYear, .fcalMonth, .fcalDay, .fcalYear, .gcalMonth, .gcalDay, .gcalYear,
    .statusFlags);
  mhr_master_model m (.core_clk, .reqReady, .wrReady, .rdValid, .rdData, .done, .excValid,
    .reqValid, .reqWrite, .reqAddr, .reqQty, .wrValid, .wrData);
  always @(posedge core_clk) begin
    if (commitValid) nCommit <= nCommit + 1;
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      numErrors++;
      endSim();
    end
  end
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    samplesChecked++;
    if (got !== exp) begin
      numErrors++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic endSim();
    $display("checked %0d mismatches %0d", samplesChecked, numErrors);
    if (numErrors == 0 && samplesChecked > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  task automatic testH2();
    h2Ppm = 32'h01312d00;
    m.xfer(1'b0, 16'h0000, 16'h0002);
    check("h2 upper", 32'h0131, m.words[0]);
    check("h2 lower", 32'h2d00, m.words[1]);
    m.xfer(1'b0, 16'h0000, 16'h0001);
    h2Ppm = 32'h0000abcd;
    m.xfer(1'b0, 16'h0001, 16'h0001);
    check("unpaired lower", 32'h2d00, m.words[0]);
    $display("testH2 done");
  endtask
  task automatic testScaled();
    logic [15:0] e[6] = '{16'h0000, 16'h0000, 16'h0131, 16'h2d00, 16'h0262, 16'h5a00};
    tempCenti = 16'hd8f0;
    rateDay = 32'hfeced300;
    rateMonth = 32'h01312d00;
    m.xfer(1'b0, 16'h0008, 16'h0001);
    check("temp low", 32'h0000, m.words[0]);
    tempCenti = 16'h4e20;
    m.xfer(1'b0, 16'h0008, 16'h0001);
    check("temp high", 32'h7530, m.words[0]);
    m.xfer(1'b0, 16'h000d, 16'h0006);
    foreach (e[i]) check("rate word", e[i], m.words[i]);
    $display("testScaled done");
  endtask
  task automatic testInfo();
    logic [15:0] e[8] = '{16'h0c1f, 16'h07e8, 16'h0102, 16'h07e9, 16'h0, 16'h0, 16'h0304,
      16'h07ea};
    logic [15:0] w;
    m.xfer(1'b0, 16'h001f, 16'h000a);
    for (int i = 0; i < 10; i++) begin
      w = modelStr[159 - 16 * i -: 16];
      if (i == 9) w[7:0] = 8'h00;
      check("model word", w, m.words[i]);
    end
    m.xfer(1'b0, 16'h0051, 16'h0008);
    foreach (e[i]) check("date word", e[i], m.words[i]);
    m.xfer(1'b0, 16'h0013, 16'h000c);
    for (int i = 0; i < 12; i++) check("reserved", 32'h0, m.words[i]);
    m.xfer(1'b0, 16'h0028, 16'h0001);
    check("model end", 32'h00005300, m.words[0]);
    m.xfer(1'b0, 16'h0062, 16'h0001);
    check("firmware end", 32'h00004600, m.words[0]);
    m.xfer(1'b0, 16'h0063, 16'h0001);
    check("reserved one", 32'h0, m.words[0]);
    $display("testInfo done");
  endtask
  task automatic testRange();
    logic [31:0] r;
    m.xfer(1'b0, 16'h006f, 16'h0001);
    check("status", 32'h00a5, m.words[0]);
    m.xfer(1'b0, 16'h006f, 16'h0002);
    r = {7'h0, m.gotExc, excFunc, excCode, 8'(m.words.size())};
    check("read exc", 32'h01830200, r);
    m.xfer(1'b1, 16'h006e, 16'h0003);
    r = {7'h0, m.gotExc, excFunc, excCode, 8'(m.words.size())};
    check("write exc", 32'h01860200, r);
    m.xfer(1'b0, 16'h0000, 16'h0000);
    r = {7'h0, m.gotExc, excFunc, excCode, 8'(m.words.size())};
    check("zero count", 32'h01830300, r);
    m.xfer(1'b0, 16'h0000, 16'h0070);
    check("full span", 32'h0070, {23'h0, m.gotExc, 8'(m.words.size())});
    $display("testRange done");
  endtask
  task automatic testWrite();
    int n0;
    n0 = nCommit;
    m.write(16'h000d, 16'h0002, '{16'h1234, 16'h5678}, 3);
    check("wide data", 32'h12345678, commitData);
    check("wide shape", 32'h000d0001, {commitAddr, 15'h0, commitWide});
    check("wide count", 32'h1, nCommit - n0);
    m.write(16'h0008, 16'h0001, '{16'h4321}, 0);
    @(posedge core_clk) #1;
    check("narrow data", 32'h00004321, commitData);
    check("narrow shape", 32'h00080000, {commitAddr, 15'h0, commitWide});
    $display("testWrite done");
  endtask
  initial begin
    repeat (4) @(posedge core_clk);
    #1 srst = 1'b0;
    testH2();
    testScaled();
    testInfo();
    testRange();
    testWrite();
    endSim();
  end
endmodule
`default_nettype wire

// ===== verilog/mhr_regbank.sv
// Purpose: Holding register bank: range check, word streaming, pair latch, write pairing.
// Assumes: Framing and CRC are handled outside; one request is active at a time.
// Notes: Read words stream out one per cycle with no stall; write words wait on wrValid.
`timescale 1ns/1ns
`default_nettype none
module mhr_regbank
  import mhr_pkg::*;
(
  input wire logic core_clk,
  input wire logic srst,
  input wire logic reqValid,
  input wire logic reqWrite,
  input wire logic [ADDR_W-1:0] reqAddr,
  input wire logic [QTY_W-1:0] reqQty,
  output logic reqReady,
  input wire logic wrValid,
  input wire logic [DATA_W-1:0] wrData,
  output logic wrReady,
  output logic rdValid,
  output logic [DATA_W-1:0] rdData,
  output logic done,
  output logic excValid,
  output logic [7:0] excFunc,
  output logic [7:0] excCode,
  output logic commitValid,
  output logic [ADDR_W-1:0] commitAddr,
  output logic [31:0] commitData,
  output logic commitWide,
  input wire logic [31:0] h2Ppm,
  input wire logic signed [15:0] tempCenti,
  input wire logic signed [31:0] rateDay,
  input wire logic signed [31:0] rateWeek,
  input wire logic signed [31:0] rateMonth,
  input wire logic [STR_W-1:0] modelStr,
  input wire logic [STR_W-1:0] prodSerialStr,
  input wire logic [STR_W-1:0] sensSerialStr,
  input wire logic [STR_W-1:0] fwRevStr,
  input wire logic [7:0] buildMonth,
  input wire logic [7:0] buildDay,
  input wire logic [15:0] buildYear,
  input wire logic [7:0] fcalMonth,
  input wire logic [7:0] fcalDay,
  input wire logic [15:0] fcalYear,
  input wire logic [7:0] gcalMonth,
  input wire logic [7:0] gcalDay,
  input wire logic [15:0] gcalYear,
  input wire logic [15:0] statusFlags
);

  typedef struct packed {
    mhr_state_t state;
    logic [ADDR_W-1:0] cur;
    logic [QTY_W-1:0] left;
    logic [DATA_W-1:0] lowLatch;
    logic pendValid;
    logic [ADDR_W-1:0] pendAddr;
    logic [DATA_W-1:0] pendWord;
    logic rdValid;
    logic [DATA_W-1:0] rdData;
    logic done;
    logic excValid;
    logic [7:0] excFunc;
    logic [7:0] excCode;
    logic commitValid;
    logic [ADDR_W-1:0] commitAddr;
    logic [31:0] commitData;
    logic commitWide;
  } mhr_regs_t;

  mhr_regs_t st_r;
  mhr_regs_t st_nxt;
  logic [DATA_W-1:0] curWord;
  logic [DATA_W-1:0] nextWord;
  logic [ADDR_W-1:0] nextAddr;
  logic [16:0] reqEnd;
  logic reqOutOfRange;

  assign nextAddr = st_r.cur + 16'h0001;
  // End is one past the last register touched; 17 bits so a wrap cannot pass the check
  assign reqEnd = {1'b0, reqAddr} + {1'b0, reqQty};
  assign reqOutOfRange = reqEnd > ({1'b0, ADDR_LAST} + 17'h00001);

  mhr_word_mux curMux (
    .addr(st_r.cur),
    .h2Ppm(h2Ppm),
    .tempCenti(tempCenti),
    .rateDay(rateDay),
    .rateWeek(rateWeek),
    .rateMonth(rateMonth),
    .modelStr(modelStr),
    .prodSerialStr(prodSerialStr),
    .sensSerialStr(sensSerialStr),
    .fwRevStr(fwRevStr),
    .buildMonth(buildMonth),
    .buildDay(buildDay),
    .buildYear(buildYear),
    .fcalMonth(fcalMonth),
    .fcalDay(fcalDay),
    .fcalYear(fcalYear),
    .gcalMonth(gcalMonth),
    .gcalDay(gcalDay),
    .gcalYear(gcalYear),
    .statusFlags(statusFlags),
    .word(curWord)
  );

  // Second lookup fetches the partner word in the same cycle as the upper word
  mhr_word_mux lowMux (
    .addr(nextAddr),
    .h2Ppm(h2Ppm),
    .tempCenti(tempCenti),
    .rateDay(rateDay),
    .rateWeek(rateWeek),
    .rateMonth(rateMonth),
    .modelStr(modelStr),
    .prodSerialStr(prodSerialStr),
    .sensSerialStr(sensSerialStr),
    .fwRevStr(fwRevStr),
    .buildMonth(buildMonth),
    .buildDay(buildDay),
    .buildYear(buildYear),
    .fcalMonth(fcalMonth),
    .fcalDay(fcalDay),
    .fcalYear(fcalYear),
    .gcalMonth(gcalMonth),
    .gcalDay(gcalDay),
    .gcalYear(gcalYear),
    .statusFlags(statusFlags),
    .word(nextWord)
  );

  assign reqReady = (st_r.state == ST_IDLE);
  assign wrReady = (st_r.state == ST_WRITE);

  logic reqBadQty;
  logic reqExc;
  logic [7:0] reqExcFunc;
  logic [7:0] reqExcCode;
  logic curIsUpper;
  logic curIsLower;
  logic lastWord;
  logic pendPartner;

  // An empty request is screened first and reported with its own code
  assign reqBadQty = (reqQty == 16'h0000);
  assign reqExc = reqBadQty || reqOutOfRange;
  // The refused function keeps the request kind with its top bit set
  assign reqExcFunc = reqWrite ? FUNC_WR_EXC : FUNC_RD_EXC;
  assign reqExcCode = reqBadQty ? EXC_ILLEGAL_VALUE : EXC_ILLEGAL_ADDR;

  // Pair role of the word under the pointer
  assign curIsUpper = mhr_is_pair_upper(st_r.cur);
  assign curIsLower = mhr_is_pair_lower(st_r.cur);
  assign lastWord = (st_r.left == 16'h0001);
  // Only the word right after the held upper word completes it; any other word
  // drops the held one, so a master that skips the lower word loses the pair
  assign pendPartner = st_r.pendValid && (st_r.cur == st_r.pendAddr + 16'h0001);

  always_comb begin
    st_nxt = st_r;
    st_nxt.rdValid = 1'b0;
    st_nxt.done = 1'b0;
    st_nxt.excValid = 1'b0;
    st_nxt.commitValid = 1'b0;
    unique case (st_r.state)
      ST_IDLE: begin
        if (reqValid) begin
          if (reqExc) begin
            // No data is returned and nothing is written for a rejected request
            st_nxt.excValid = 1'b1;
            st_nxt.excFunc = reqExcFunc;
            st_nxt.excCode = reqExcCode;
          end else begin
            st_nxt.state = reqWrite ? ST_WRITE : ST_READ;
            st_nxt.cur = reqAddr;
            st_nxt.left = reqQty;
          end
        end
      end
      ST_READ: begin
        st_nxt.rdValid = 1'b1;
        if (curIsLower) begin
          // Always served from the latch, even without a fresh upper read
          st_nxt.rdData = st_r.lowLatch;
        end else begin
          st_nxt.rdData = curWord;
        end
        if (curIsUpper) begin
          st_nxt.lowLatch = nextWord;
        end
        st_nxt.cur = nextAddr;
        st_nxt.left = st_r.left - 16'h0001;
        if (lastWord) begin
          st_nxt.done = 1'b1;
          st_nxt.state = ST_IDLE;
        end
      end
      ST_WRITE: begin
        if (wrValid) begin
          if (curIsUpper) begin
            st_nxt.pendValid = 1'b1;
            st_nxt.pendAddr = st_r.cur;
            st_nxt.pendWord = wrData;
          end else if (pendPartner) begin
            st_nxt.pendValid = 1'b0;
            st_nxt.commitValid = 1'b1;
            st_nxt.commitWide = 1'b1;
            st_nxt.commitAddr = st_r.pendAddr;
            st_nxt.commitData = {st_r.pendWord, wrData};
          end else begin
            // A stray word drops any unmatched upper word
            st_nxt.pendValid = 1'b0;
            st_nxt.commitValid = 1'b1;
            st_nxt.commitWide = 1'b0;
            st_nxt.commitAddr = st_r.cur;
            st_nxt.commitData = {16'h0000, wrData};
          end
          st_nxt.cur = nextAddr;
          st_nxt.left = st_r.left - 16'h0001;
          if (lastWord) begin
            st_nxt.done = 1'b1;
            st_nxt.state = ST_IDLE;
          end
        end
      end
      default: begin
        st_nxt.state = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign rdValid = st_r.rdValid;
  assign rdData = st_r.rdData;
  assign done = st_r.done;
  assign excValid = st_r.excValid;
  assign excFunc = st_r.excFunc;
  assign excCode = st_r.excCode;
  assign commitValid = st_r.commitValid;
  assign commitAddr = st_r.commitAddr;
  assign commitData = st_r.commitData;
  assign commitWide = st_r.commitWide;

endmodule
`default_nettype wire

// ===== verilog/mhr_word_mux.sv
// Purpose: Maps one register address to its 16-bit word from the live values.
// Assumes: Values are stable while sampled; strings hold the first character in the top byte.
// Notes: Purely combinational; unassigned addresses read as zero.
`timescale 1ns/1ns
`default_nettype none
module mhr_word_mux
  import mhr_pkg::*;
(
  input wire logic [15:0] addr,
  input wire logic [31:0] h2Ppm,
  input wire logic signed [15:0] tempCenti,
  input wire logic signed [31:0] rateDay,
  input wire logic signed [31:0] rateWeek,
  input wire logic signed [31:0] rateMonth,
  input wire logic [STR_W-1:0] modelStr,
  input wire logic [STR_W-1:0] prodSerialStr,
  input wire logic [STR_W-1:0] sensSerialStr,
  input wire logic [STR_W-1:0] fwRevStr,
  input wire logic [7:0] buildMonth,
  input wire logic [7:0] buildDay,
  input wire logic [15:0] buildYear,
  input wire logic [7:0] fcalMonth,
  input wire logic [7:0] fcalDay,
  input wire logic [15:0] fcalYear,
  input wire logic [7:0] gcalMonth,
  input wire logic [7:0] gcalDay,
  input wire logic [15:0] gcalYear,
  input wire logic [15:0] statusFlags,
  output logic [15:0] word
);

  logic [31:0] rateDayB;
  logic [31:0] rateWeekB;
  logic [31:0] rateMonthB;
  logic [15:0] tempBiased;

  assign rateDayB = rateDay + RATE_BIAS;
  assign rateWeekB = rateWeek + RATE_BIAS;
  assign rateMonthB = rateMonth + RATE_BIAS;
  assign tempBiased = tempCenti + TEMP_OFFSET;

  // Last byte is forced to zero so the string is always terminated
  function automatic logic [15:0] strWord(input logic [STR_W-1:0] s, input logic [15:0] idx);
    logic [STR_W-1:0] t;
    t = {s[STR_W-1:8], 8'h00};
    return t[STR_W-1 - 16*idx -: 16];
  endfunction

  always_comb begin
    word = RESET_WORD;
    if (addr >= ADDR_MODEL_STR && addr < ADDR_MODEL_STR + 16'(STR_WORDS)) begin
      word = strWord(modelStr, addr - ADDR_MODEL_STR);
    end else if (addr >= ADDR_PROD_SN_STR && addr < ADDR_PROD_SN_STR + 16'(STR_WORDS)) begin
      word = strWord(prodSerialStr, addr - ADDR_PROD_SN_STR);
    end else if (addr >= ADDR_SENS_SN_STR && addr < ADDR_SENS_SN_STR + 16'(STR_WORDS)) begin
      word = strWord(sensSerialStr, addr - ADDR_SENS_SN_STR);
    end else if (addr >= ADDR_FW_STR && addr < ADDR_FW_STR + 16'(STR_WORDS)) begin
      word = strWord(fwRevStr, addr - ADDR_FW_STR);
    end else begin
      case (addr)
        ADDR_H2_UP: word = h2Ppm[31:16];
        ADDR_H2_LO: word = h2Ppm[15:0];
        ADDR_TEMP: word = tempBiased;
        ADDR_RATE_DAY_UP: word = rateDayB[31:16];
        ADDR_RATE_DAY_LO: word = rateDayB[15:0];
        ADDR_RATE_WEEK_UP: word = rateWeekB[31:16];
        ADDR_RATE_WEEK_LO: word = rateWeekB[15:0];
        ADDR_RATE_MONTH_UP: word = rateMonthB[31:16];
        ADDR_RATE_MONTH_LO: word = rateMonthB[15:0];
        ADDR_BUILD_MD: word = {buildMonth, buildDay};
        ADDR_BUILD_YR: word = buildYear;
        ADDR_FCAL_MD: word = {fcalMonth, fcalDay};
        ADDR_FCAL_YR: word = fcalYear;
        ADDR_GCAL_MD: word = {gcalMonth, gcalDay};
        ADDR_GCAL_YR: word = gcalYear;
        ADDR_STATUS: word = statusFlags;
        default: word = RESET_WORD;
      endcase
    end
  end

endmodule
`default_nettype wire
